// ==== rtl/boot_opt_pkg.sv ====
// package: offsets, field layout, codes and carriers for the option byte decoder
package boot_opt_pkg;
  // register map (byte addresses on the register port)
  localparam logic [12:0] OFS_OSC_FLASH = 13'h00c2;
  localparam logic [12:0] OFS_DEBUG = 13'h00c3;
  localparam logic [12:0] OFS_OSC_FLASH_MIR = 13'h10c2;
  localparam logic [12:0] OFS_DEBUG_MIR = 13'h10c3;
  localparam logic [12:0] OFS_CTRL = 13'h0100;
  localparam logic [12:0] OFS_STATUS = 13'h0101;
  localparam logic [12:0] OFS_FREQ = 13'h0102;
  // storage slots in fetch order
  localparam logic [1:0] SLOT_OSC = 2'h0;
  localparam logic [1:0] SLOT_DBG = 2'h1;
  localparam logic [1:0] SLOT_OSC_MIR = 2'h2;
  localparam logic [1:0] SLOT_DBG_MIR = 2'h3;
  localparam logic [1:0] SLOT_SWAP_XOR = 2'h2;
  // oscillator / flash option byte fields
  localparam int FLASH_MODE_LSB = 6;
  localparam int OSC_FIXED_LSB = 4;
  localparam logic [1:0] OSC_FIXED_VAL = 2'h2;
  localparam logic [1:0] MODE_LOW_VOLTAGE = 2'h0;
  localparam logic [1:0] MODE_PROHIBITED = 2'h1;
  localparam logic [1:0] MODE_LOW_SPEED = 2'h2;
  localparam logic [1:0] MODE_HIGH_SPEED = 2'h3;
  localparam logic [3:0] FREQ_CODE_32 = 4'h8;
  localparam logic [3:0] FREQ_CODE_24 = 4'h0;
  localparam logic [3:0] FREQ_CODE_16 = 4'h9;
  localparam logic [3:0] FREQ_CODE_12 = 4'h1;
  localparam logic [3:0] FREQ_CODE_8 = 4'ha;
  localparam logic [3:0] FREQ_CODE_4 = 4'hb;
  localparam logic [3:0] FREQ_CODE_1 = 4'hd;
  localparam logic [5:0] LIMIT_LOW_VOLTAGE_MHZ = 6'h04;
  localparam logic [5:0] LIMIT_LOW_SPEED_MHZ = 6'h08;
  localparam logic [5:0] LIMIT_HIGH_SPEED_MHZ = 6'h20;
  localparam logic [5:0] LIMIT_HIGH_SPEED_LOW_SUPPLY_MHZ = 6'h10;
  // debug option byte fields
  localparam int DEBUG_ENABLE_BIT = 7;
  localparam int DEBUG_NO_ERASE_BIT = 0;
  localparam logic [7:0] DEBUG_FIXED_MASK = 8'h7e;
  localparam logic [7:0] DEBUG_FIXED_VAL = 8'h04;
  // control register
  localparam int CTRL_AUTH_FAIL_BIT = 0;
  // strap settle count after reset release
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  typedef enum {ST_SETTLE, ST_FETCH, ST_DECODE, ST_RUN} load_state_t;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [12:0] addr;
    logic rd;
  } nvm_req_t;

  typedef struct packed {
    logic [3:0] osc_freq_code;
    logic [5:0] freq_mhz;
    logic [1:0] flash_mode;
    logic debug_enable_set;
    logic debug_no_erase_sel;
  } boot_cfg_t;
endpackage : boot_opt_pkg

// ==== rtl/boot_option_byte_decoder.sv ====
// boot option byte decoder: fetches, swaps, checks and holds the boot option bytes
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module boot_option_byte_decoder (
  input wire logic clk_sys,
  input wire logic rst_n,
  input boot_opt_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output boot_opt_pkg::nvm_req_t nvm_req,
  input wire logic [7:0] nvm_rdata,
  input wire logic boot_swap_pin,
  input wire logic supply_high_pin,
  output boot_opt_pkg::boot_cfg_t cfg,
  output logic cfg_valid,
  output logic cpu_release,
  output logic flash_erase_req
);
  import boot_opt_pkg::*;

  load_state_t state;
  logic [1:0] settle_cnt;
  logic [1:0] swap_meta, supply_meta;
  logic boot_swap, supply_high;
  logic [1:0] issue_idx, cap_idx;
  logic issue_done, cap_pending;
  logic [7:0] opt [4];
  logic [7:0] status;
  logic last_cap;
  logic [1:0] mode_code;
  logic [5:0] freq_mhz_dec, mode_limit;
  logic osc_err, mode_err, debug_err, freq_over;
  logic auth_fail_wr;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      swap_meta <= 2'h0;
      supply_meta <= 2'h0;
    end else begin
      swap_meta <= {swap_meta[0], boot_swap_pin};
      supply_meta <= {supply_meta[0], supply_high_pin};
    end
  end

  // strap caught once after the chain has settled, never from the reset itself
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      boot_swap <= 1'b0;
      supply_high <= 1'b0;
    end else if (state == ST_SETTLE && settle_cnt == STRAP_SETTLE_CYCLES) begin
      boot_swap <= swap_meta[1];
      supply_high <= supply_meta[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // load sequencer
  assign last_cap = cap_pending && cap_idx == SLOT_DBG_MIR;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_SETTLE;
      settle_cnt <= 2'h0;
    end else begin
      unique case (state)
        ST_SETTLE: begin
          settle_cnt <= settle_cnt + 2'h1;
          if (settle_cnt == STRAP_SETTLE_CYCLES) begin
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (last_cap) begin
            state <= ST_DECODE;
          end
        end
        ST_DECODE: state <= ST_RUN;
        ST_RUN: state <= ST_RUN; // held until the next reset
      endcase
    end
  end

  function automatic logic [12:0] slot_addr(input logic [1:0] slot);
    unique case (slot)
      SLOT_OSC: slot_addr = OFS_OSC_FLASH;
      SLOT_DBG: slot_addr = OFS_DEBUG;
      SLOT_OSC_MIR: slot_addr = OFS_OSC_FLASH_MIR;
      SLOT_DBG_MIR: slot_addr = OFS_DEBUG_MIR;
    endcase
  endfunction : slot_addr

  // one read per cycle; data returns the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nvm_req <= '0;
      issue_idx <= 2'h0;
      issue_done <= 1'b0;
      cap_idx <= 2'h0;
      cap_pending <= 1'b0;
    end else begin
      cap_pending <= nvm_req.rd;
      cap_idx <= issue_idx - 2'h1;
      if (state == ST_FETCH && !issue_done) begin
        nvm_req.rd <= 1'b1;
        nvm_req.addr <= slot_addr(issue_idx);
        issue_idx <= issue_idx + 2'h1;
        issue_done <= issue_idx == SLOT_DBG_MIR;
      end else begin
        nvm_req.rd <= 1'b0;
      end
    end
  end

  // boot swap exchanges each primary with its mirror on the way in
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        opt[i] <= 8'h00;
      end
    end else if (cap_pending && state == ST_FETCH) begin
      opt[cap_idx ^ (boot_swap ? SLOT_SWAP_XOR : 2'h0)] <= nvm_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode of the primary copies
  assign mode_code = opt[SLOT_OSC][FLASH_MODE_LSB +: 2];

  always_comb begin
    osc_err = opt[SLOT_OSC][OSC_FIXED_LSB +: 2] != OSC_FIXED_VAL;
    unique case (opt[SLOT_OSC][3:0])
      FREQ_CODE_32: freq_mhz_dec = 6'h20;
      FREQ_CODE_24: freq_mhz_dec = 6'h18;
      FREQ_CODE_16: freq_mhz_dec = 6'h10;
      FREQ_CODE_12: freq_mhz_dec = 6'h0c;
      FREQ_CODE_8: freq_mhz_dec = 6'h08;
      FREQ_CODE_4: freq_mhz_dec = 6'h04;
      FREQ_CODE_1: freq_mhz_dec = 6'h01;
      default: begin
        freq_mhz_dec = 6'h00;
        osc_err = 1'b1;
      end
    endcase
    mode_err = 1'b0;
    unique case (mode_code)
      MODE_LOW_VOLTAGE: mode_limit = LIMIT_LOW_VOLTAGE_MHZ;
      MODE_LOW_SPEED: mode_limit = LIMIT_LOW_SPEED_MHZ;
      MODE_HIGH_SPEED: mode_limit = supply_high ? LIMIT_HIGH_SPEED_MHZ
                                    : LIMIT_HIGH_SPEED_LOW_SUPPLY_MHZ;
      MODE_PROHIBITED: begin
        mode_limit = 6'h00;
        mode_err = 1'b1;
      end
    endcase
    freq_over = freq_mhz_dec > mode_limit;
    debug_err = (opt[SLOT_DBG] & DEBUG_FIXED_MASK) != DEBUG_FIXED_VAL
             || (!opt[SLOT_DBG][DEBUG_ENABLE_BIT]
                 && opt[SLOT_DBG][DEBUG_NO_ERASE_BIT]);
  end

  // latched once; a bad debug byte leaves debugging off as the safe default
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg <= '0;
      cfg_valid <= 1'b0;
      status <= 8'h00;
    end else if (state == ST_DECODE) begin
      cfg.osc_freq_code <= opt[SLOT_OSC][3:0];
      cfg.freq_mhz <= freq_mhz_dec;
      cfg.flash_mode <= mode_code;
      cfg.debug_enable_set <= opt[SLOT_DBG][DEBUG_ENABLE_BIT] && !debug_err;
      cfg.debug_no_erase_sel <= opt[SLOT_DBG][DEBUG_NO_ERASE_BIT] && !debug_err;
      cfg_valid <= !(osc_err || mode_err || debug_err || freq_over);
      status <= {freq_over, opt[SLOT_DBG] != opt[SLOT_DBG_MIR],
                 opt[SLOT_OSC] != opt[SLOT_OSC_MIR], debug_err, mode_err, osc_err,
                 boot_swap, 1'b1};
    end
  end

  // processor held until the settings are fixed
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cpu_release <= 1'b0;
    end else if (state == ST_DECODE) begin
      cpu_release <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port; option bytes are read only, writes to them are dropped
  assign auth_fail_wr = reg_req.wr && reg_req.addr == OFS_CTRL
                     && reg_req.wdata[CTRL_AUTH_FAIL_BIT];

  // erase only when debug runs with no-erase clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flash_erase_req <= 1'b0;
    end else begin
      flash_erase_req <= auth_fail_wr && state == ST_RUN && cfg.debug_enable_set
                      && !cfg.debug_no_erase_sel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        OFS_OSC_FLASH: reg_rdata <= opt[SLOT_OSC];
        OFS_DEBUG: reg_rdata <= opt[SLOT_DBG];
        OFS_OSC_FLASH_MIR: reg_rdata <= opt[SLOT_OSC_MIR];
        OFS_DEBUG_MIR: reg_rdata <= opt[SLOT_DBG_MIR];
        OFS_STATUS: reg_rdata <= status;
        OFS_FREQ: reg_rdata <= {2'h0, cfg.freq_mhz};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence fetch_done_s;
    last_cap ##1 (state == ST_DECODE);
  endsequence
  sequence release_s;
    ##1 cpu_release && cfg_valid == $past(!(osc_err || mode_err || debug_err || freq_over));
  endsequence

  release_after_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    last_cap |-> fetch_done_s ##0 release_s) else $error("release not after load");
  cfg_frozen_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_release && $past(cpu_release) |-> $stable(cfg) && $stable(status))
    else $error("settings moved after release");
  no_early_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state != ST_RUN |-> !cpu_release) else $error("processor released early");
  freq_top_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_release && cfg.osc_freq_code == FREQ_CODE_32 |-> cfg.freq_mhz == 6'h20)
    else $error("32 MHz code misdecoded");
  fixed_bits_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_release && opt[SLOT_OSC][5:4] != 2'h2 |-> status[2] && !cfg_valid)
    else $error("oscillator fixed bits not checked");
  low_volt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_release && cfg.flash_mode == MODE_LOW_VOLTAGE && cfg.freq_mhz > 6'h04 |-> status[7])
    else $error("low-voltage limit missed");
  low_speed_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_release && cfg.flash_mode == MODE_LOW_SPEED |-> status[7] == (cfg.freq_mhz > 6'h08))
    else $error("low-speed limit wrong");
  mode_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_release && cfg.flash_mode == MODE_PROHIBITED |-> status[3] && !cfg_valid)
    else $error("prohibited mode accepted");
  osc_swap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nvm_req.rd && nvm_req.addr == OFS_OSC_FLASH && boot_swap |-> ##2 opt[2] == $past(nvm_rdata))
    else $error("oscillator byte not swapped");
  dbg_swap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nvm_req.rd && nvm_req.addr == OFS_DEBUG_MIR && boot_swap |-> ##2 opt[1] == $past(nvm_rdata))
    else $error("debug byte not swapped");
  dbg_prohibit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_release && !opt[1][7] && opt[1][0] |-> !cfg.debug_enable_set && status[4])
    else $error("prohibited debug code accepted");
  erase_fail_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    auth_fail_wr && cpu_release && cfg.debug_enable_set && !cfg.debug_no_erase_sel
    |=> flash_erase_req ##1 !flash_erase_req) else $error("erase not requested");
  keep_flash_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg.debug_no_erase_sel |=> !flash_erase_req) else $error("flash erased with no-erase set");

  // fetch walks the four bytes on consecutive cycles, then the memory port stays silent
  sequence fetch_order_s;
    nvm_req.rd && nvm_req.addr == OFS_OSC_FLASH
    ##1 nvm_req.rd && nvm_req.addr == OFS_DEBUG
    ##1 nvm_req.rd && nvm_req.addr == OFS_OSC_FLASH_MIR
    ##1 nvm_req.rd && nvm_req.addr == OFS_DEBUG_MIR
    ##1 !nvm_req.rd;
  endsequence

  fetch_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == ST_FETCH && issue_idx == SLOT_OSC && !issue_done |=> fetch_order_s)
    else $error("option byte reads out of order");
  fetch_once_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_release |-> !nvm_req.rd) else $error("memory read after release");
  opt_frozen_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_release && $past(cpu_release) |-> $stable(opt[0]) && $stable(opt[1])
    && $stable(opt[2]) && $stable(opt[3])) else $error("option copy moved after release");
  erase_after_run_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flash_erase_req |-> cpu_release) else $error("erase requested before release");
  no_erase_en_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg.debug_no_erase_sel |-> cfg.debug_enable_set) else $error("no-erase without debug");
  high_speed_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_release && cfg.flash_mode == MODE_HIGH_SPEED && !supply_high
    |-> status[7] == (cfg.freq_mhz > 6'h10)) else $error("low-supply limit wrong");
  osc_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_release |-> status[5] == (opt[0] != opt[2])) else $error("oscillator mirror flag wrong");
  dbg_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_release |-> status[6] == (opt[1] != opt[3])) else $error("debug mirror flag wrong");
endmodule : boot_option_byte_decoder

// ==== tb/boot_option_byte_decoder_test.sv ====
// self-checking bench for the boot option byte decoder
`timescale 1ns/10ps
module boot_option_byte_decoder_test;
  import boot_opt_pkg::*;
  typedef struct packed {
    logic [7:0] osc, osc_m, dbg, dbg_m;
    logic swap, sup;
    logic [5:0] mhz;
    logic [1:0] mode;
    logic valid, en, ne;
    logic [7:0] st;
  } row_t;
  logic clk_sys, rst_n, boot_swap_pin, supply_high_pin, cfg_valid, cpu_release, flash_erase_req;
  reg_req_t reg_req;
  nvm_req_t nvm_req;
  boot_cfg_t cfg;
  logic [7:0] reg_rdata, nvm_rdata, rd_val;
  logic [7:0] mem [4];
  int err_total, total_checks, cycles;
  row_t rows [15];
  boot_option_byte_decoder dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .nvm_req(nvm_req), .nvm_rdata(nvm_rdata),
    .boot_swap_pin(boot_swap_pin), .supply_high_pin(supply_high_pin), .cfg(cfg),
    .cfg_valid(cfg_valid), .cpu_release(cpu_release), .flash_erase_req(flash_erase_req));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // option-byte memory answers one cycle after a read; between reads the line toggles
  // so a design that samples late never sees a stale copy of the last byte
  always @(posedge clk_sys) begin
    if (nvm_req.rd) nvm_rdata <= mem[{nvm_req.addr[12], nvm_req.addr[0]}];
    else nvm_rdata <= ~nvm_rdata;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_read(input logic [12:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_req.rd <= 1'b1;
    reg_req.addr <= a;
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  task automatic reg_write(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req.wr <= 1'b1;
    reg_req.addr <= a;
    reg_req.wdata <= d;
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask : reg_write
  task automatic boot(input row_t r);
    int n;
    mem[0] = r.osc;
    mem[1] = r.dbg;
    mem[2] = r.osc_m;
    mem[3] = r.dbg_m;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    boot_swap_pin <= r.swap;
    supply_high_pin <= r.sup;
    repeat (2) @(posedge clk_sys);
    #1 check({6'h00, cpu_release, cfg_valid}, 8'h00);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    n = 0;
    while (cpu_release !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1 n = n + 1;
    end
    check({7'h00, cpu_release}, 8'h01);
  endtask : boot
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    nvm_rdata = 8'h00;
    boot_swap_pin = 1'b0;
    supply_high_pin = 1'b0;
    err_total = 0;
    total_checks = 0;
    cycles = 0;
    // osc, mirror, dbg, mirror, swap, supply | mhz, mode, valid, dbg enable, no-erase, status
    rows[0] = '{8'he8, 8'he8, 8'h84, 8'h84, 1'b0, 1'b1, 6'h20, 2'h3, 1'b1, 1'b1, 1'b0, 8'h01};
    rows[1] = '{8'he8, 8'he8, 8'h84, 8'h84, 1'b0, 1'b0, 6'h20, 2'h3, 1'b0, 1'b1, 1'b0, 8'h81};
    rows[2] = '{8'he9, 8'he9, 8'h85, 8'h85, 1'b0, 1'b0, 6'h10, 2'h3, 1'b1, 1'b1, 1'b1, 8'h01};
    rows[3] = '{8'h2b, 8'h2b, 8'h04, 8'h04, 1'b0, 1'b1, 6'h04, 2'h0, 1'b1, 1'b0, 1'b0, 8'h01};
    rows[4] = '{8'h2a, 8'h2a, 8'h04, 8'h04, 1'b0, 1'b1, 6'h08, 2'h0, 1'b0, 1'b0, 1'b0, 8'h81};
    rows[5] = '{8'haa, 8'haa, 8'h05, 8'h05, 1'b0, 1'b1, 6'h08, 2'h2, 1'b0, 1'b0, 1'b0, 8'h11};
    rows[6] = '{8'ha0, 8'ha0, 8'h84, 8'h84, 1'b0, 1'b1, 6'h18, 2'h2, 1'b0, 1'b1, 1'b0, 8'h81};
    rows[7] = '{8'had, 8'had, 8'h84, 8'h84, 1'b0, 1'b1, 6'h01, 2'h2, 1'b1, 1'b1, 1'b0, 8'h01};
    rows[8] = '{8'he1, 8'he1, 8'h84, 8'h84, 1'b0, 1'b1, 6'h0c, 2'h3, 1'b1, 1'b1, 1'b0, 8'h01};
    rows[9] = '{8'he3, 8'he3, 8'h84, 8'h84, 1'b0, 1'b1, 6'h00, 2'h3, 1'b0, 1'b1, 1'b0, 8'h05};
    rows[10] = '{8'hf8, 8'hf8, 8'h84, 8'h84, 1'b0, 1'b1, 6'h20, 2'h3, 1'b0, 1'b1, 1'b0, 8'h05};
    rows[11] = '{8'h68, 8'h68, 8'h84, 8'h84, 1'b0, 1'b1, 6'h20, 2'h1, 1'b0, 1'b1, 1'b0, 8'h89};
    rows[12] = '{8'he8, 8'he8, 8'hc4, 8'hc4, 1'b0, 1'b1, 6'h20, 2'h3, 1'b0, 1'b0, 1'b0, 8'h11};
    rows[13] = '{8'he8, 8'he9, 8'h84, 8'h85, 1'b0, 1'b1, 6'h20, 2'h3, 1'b1, 1'b1, 1'b0, 8'h61};
    rows[14] = '{8'he8, 8'he9, 8'h84, 8'h85, 1'b1, 1'b1, 6'h10, 2'h3, 1'b1, 1'b1, 1'b1, 8'h63};
    repeat (2) @(posedge clk_sys);
    foreach (rows[i]) begin
      boot(rows[i]);
      check({2'h0, cfg.freq_mhz}, {2'h0, rows[i].mhz});
      check({4'h0, cfg.osc_freq_code},
            {4'h0, (rows[i].swap ? rows[i].osc_m[3:0] : rows[i].osc[3:0])});
      check({6'h00, cfg.flash_mode}, {6'h00, rows[i].mode});
      check({7'h00, cfg_valid}, {7'h00, rows[i].valid});
      check({6'h00, cfg.debug_enable_set, cfg.debug_no_erase_sel},
            {6'h00, rows[i].en, rows[i].ne});
      reg_read(OFS_STATUS, rd_val);
      // the prohibited flash mode has a limit of zero, so any nonzero decoded frequency counts as over it
      check(rd_val, rows[i].st);
      reg_read(OFS_FREQ, rd_val);
      check(rd_val, {2'h0, rows[i].mhz});
      reg_read(OFS_OSC_FLASH, rd_val);
      check(rd_val, rows[i].swap ? rows[i].osc_m : rows[i].osc);
      reg_read(OFS_DEBUG_MIR, rd_val);
      check(rd_val, rows[i].swap ? rows[i].dbg : rows[i].dbg_m);
    end
    // no-erase selected: an authentication failure leaves flash alone
    reg_write(OFS_CTRL, 8'h01);
    #1 check({7'h00, flash_erase_req}, 8'h00);
    @(posedge clk_sys);
    #1 check({7'h00, flash_erase_req}, 8'h00);
    boot(rows[0]);
    reg_write(OFS_CTRL, 8'h01);
    #1 check({7'h00, flash_erase_req}, 8'h01);
    @(posedge clk_sys);
    #1 check({7'h00, flash_erase_req}, 8'h00);
    // option bytes are read-only and unmapped space reads as zero
    reg_write(OFS_OSC_FLASH, 8'h00);
    reg_read(OFS_OSC_FLASH, rd_val);
    check(rd_val, 8'he8);
    reg_read(13'h0055, rd_val);
    check(rd_val, 8'h00);
    // memory and straps move after release: the latched settings must not follow
    mem[0] = 8'h2b;
    mem[1] = 8'h04;
    @(posedge clk_sys);
    boot_swap_pin <= 1'b1;
    supply_high_pin <= 1'b0;
    repeat (12) begin
      @(posedge clk_sys);
      #1 check({7'h00, nvm_req.rd}, 8'h00);
    end
    check({2'h0, cfg.freq_mhz}, 8'h20);
    check({6'h00, cpu_release, cfg_valid}, 8'h03);
    close_out();
  end
endmodule : boot_option_byte_decoder_test
